/* File: core/crf_core.sv */
// banked register file of a 16-bit processor core with an axi4-lite view
// assumes decoder/alu on aclk drive the core ports; software on the same clock
`timescale 1ns/1ps
`default_nettype none

module crf_core
	import crf_pkg::*;
#(
	parameter int AXI_ADDR_W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// core read port a
	input wire crf_sel_e rd_a_sel,
	input wire crf_size_e rd_a_size,
	input wire logic rd_a_hi,
	output logic [31:0] rd_a_data,
	// core read port b
	input wire crf_sel_e rd_b_sel,
	input wire crf_size_e rd_b_size,
	input wire logic rd_b_hi,
	output logic [31:0] rd_b_data,
	// core write port
	input wire logic wr_en,
	input wire crf_sel_e wr_sel,
	input wire crf_size_e wr_size,
	input wire logic wr_hi,
	input wire logic [31:0] wr_data,
	// program counter advance and interrupt events
	input wire logic pc_step_en,
	input wire logic [2:0] pc_step,
	input wire logic hw_irq_ack,
	input wire logic sw_int_exec,
	input wire logic [5:0] sw_int_num,
	// state seen by the core
	output logic [19:0] next_instr_pointer,
	output logic [10:0] cpu_flag_word,
	// axi4-lite write address and data
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	if (AXI_ADDR_W < 7) begin : g_addr_chk
		$error("crf_core: AXI_ADDR_W must be at least 7");
	end

	// architectural storage
	logic [15:0] bank_reg [0:CRF_BANKS-1][0:CRF_BANK_SLOTS-1];
	logic [15:0] sb_reg;
	logic [15:0] usp_reg;
	logic [15:0] isp_reg;
	logic [19:0] vector_table_base_reg;
	logic [19:0] pc_reg;
	logic [10:0] flg_reg;

	logic bsel;
	logic usel;
	logic [15:0] cur_bank [0:CRF_BANK_SLOTS-1];
	logic [15:0] sp_cur;

	assign bsel = flg_reg[CRF_FLG_B];
	assign usel = flg_reg[CRF_FLG_U];

	always_comb begin
		for (int i = 0; i < CRF_BANK_SLOTS; i++) begin
			cur_bank[i] = bank_reg[bsel][i];
		end
		sp_cur = usel ? usp_reg : isp_reg;
	end

	// byte-lane merge of a bus write into an old value
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_lanes

	// operand read shared by both core ports
	function automatic logic [31:0] read_op(input crf_sel_e sel, input crf_size_e sz, input logic hi,
		input logic [15:0] d0, input logic [15:0] d1, input logic [15:0] d2, input logic [15:0] d3,
		input logic [15:0] a0, input logic [15:0] a1, input logic [15:0] fb, input logic [15:0] sp);
		logic [31:0] res;
		res = 32'h0000_0000;
		case (sel)
			CRF_SEL_D0: begin
				if (sz == CRF_SZ_BYTE) begin
					res = {24'h00_0000, hi ? d0[15:8] : d0[7:0]};
				end else if (sz == CRF_SZ_LONG) begin
					res = {d2, d0};
				end else begin
					res = {16'h0000, d0};
				end
			end
			CRF_SEL_D1: begin
				if (sz == CRF_SZ_BYTE) begin
					res = {24'h00_0000, hi ? d1[15:8] : d1[7:0]};
				end else if (sz == CRF_SZ_LONG) begin
					res = {d3, d1};
				end else begin
					res = {16'h0000, d1};
				end
			end
			CRF_SEL_D2: res = {16'h0000, d2};
			CRF_SEL_D3: res = {16'h0000, d3};
			CRF_SEL_A0: res = (sz == CRF_SZ_LONG) ? {a1, a0} : {16'h0000, a0};
			CRF_SEL_A1: res = {16'h0000, a1};
			CRF_SEL_FB: res = {16'h0000, fb};
			CRF_SEL_SB: res = {16'h0000, sb_reg};
			CRF_SEL_SP: res = {16'h0000, sp};
			CRF_SEL_USP: res = {16'h0000, usp_reg};
			CRF_SEL_ISP: res = {16'h0000, isp_reg};
			CRF_SEL_VECTOR_TABLE_BASE: res = {12'h000, vector_table_base_reg};
			CRF_SEL_PC: res = {12'h000, pc_reg};
			CRF_SEL_FLG: res = {21'h00_0000, flg_reg};
			default: res = 32'h0000_0000;
		endcase
		return res;
	endfunction : read_op

	// axi4-lite write channel capture, either order
	logic aw_got_reg;
	logic w_got_reg;
	logic [4:0] aw_idx_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic do_write;
	logic aw_got_next;
	logic w_got_next;
	logic bvalid_next;

	assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;
	assign aw_got_next = (aw_got_reg || (s_axi_awvalid && s_axi_awready)) && !do_write;
	assign w_got_next = (w_got_reg || (s_axi_wvalid && s_axi_wready)) && !do_write;
	assign bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_idx_reg <= 5'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CRF_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_idx_reg <= s_axi_awaddr[6:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			s_axi_awready <= !aw_got_next && !bvalid_next;
			s_axi_wready <= !w_got_next && !bvalid_next;
			s_axi_bvalid <= bvalid_next;
			if (do_write) begin
				s_axi_bresp <= idx_mapped(aw_idx_reg) ? CRF_RESP_OKAY : CRF_RESP_SLVERR;
			end
		end
	end

	function automatic logic idx_mapped(input logic [4:0] idx);
		return (idx < CRF_IDX_BANK0 + 5'(CRF_BANK_SLOTS))
			|| (idx >= CRF_IDX_BANK1 && idx < CRF_IDX_BANK1 + 5'(CRF_BANK_SLOTS))
			|| (idx >= CRF_IDX_VECTOR_TABLE_BASE && idx <= CRF_IDX_SP);
	endfunction : idx_mapped

	// decoded bus write strobes
	logic bus_bank_we;
	logic bus_bank_sel;
	logic [2:0] bus_slot;
	logic [4:0] bus_rel;

	always_comb begin
		bus_bank_we = 1'b0;
		bus_bank_sel = 1'b0;
		bus_rel = aw_idx_reg - CRF_IDX_BANK0;
		if (do_write && aw_idx_reg < CRF_IDX_BANK0 + 5'(CRF_BANK_SLOTS)) begin
			bus_bank_we = 1'b1;
		end else if (do_write && aw_idx_reg >= CRF_IDX_BANK1 && aw_idx_reg < CRF_IDX_BANK1 + 5'(CRF_BANK_SLOTS)) begin
			bus_bank_we = 1'b1;
			bus_bank_sel = 1'b1;
			bus_rel = aw_idx_reg - CRF_IDX_BANK1;
		end
		bus_slot = bus_rel[2:0];
	end

	// bank copies: bus write first, the core write wins on the same word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int b = 0; b < CRF_BANKS; b++) begin
				for (int s = 0; s < CRF_BANK_SLOTS; s++) begin
					bank_reg[b][s] <= CRF_RST_WORD;
				end
			end
		end else begin
			if (bus_bank_we) begin
				bank_reg[bus_bank_sel][bus_slot] <= 16'(merge_lanes({16'h0000, bank_reg[bus_bank_sel][bus_slot]},
					w_data_reg, w_strb_reg));
			end
			if (wr_en) begin
				// only the copy chosen by the present bank flag changes
				case (wr_sel)
					CRF_SEL_D0, CRF_SEL_D1: begin
						if (wr_size == CRF_SZ_BYTE && wr_hi) begin
							bank_reg[bsel][wr_sel == CRF_SEL_D0 ? CRF_SLOT_D0 : CRF_SLOT_D1][15:8] <= wr_data[7:0];
						end else if (wr_size == CRF_SZ_BYTE) begin
							bank_reg[bsel][wr_sel == CRF_SEL_D0 ? CRF_SLOT_D0 : CRF_SLOT_D1][7:0] <= wr_data[7:0];
						end else if (wr_size == CRF_SZ_LONG && wr_sel == CRF_SEL_D0) begin
							bank_reg[bsel][CRF_SLOT_D0] <= wr_data[15:0];
							bank_reg[bsel][CRF_SLOT_D2] <= wr_data[31:16];
						end else if (wr_size == CRF_SZ_LONG) begin
							bank_reg[bsel][CRF_SLOT_D1] <= wr_data[15:0];
							bank_reg[bsel][CRF_SLOT_D3] <= wr_data[31:16];
						end else begin
							bank_reg[bsel][wr_sel == CRF_SEL_D0 ? CRF_SLOT_D0 : CRF_SLOT_D1] <= wr_data[15:0];
						end
					end
					CRF_SEL_D2: bank_reg[bsel][CRF_SLOT_D2] <= wr_data[15:0];
					CRF_SEL_D3: bank_reg[bsel][CRF_SLOT_D3] <= wr_data[15:0];
					CRF_SEL_A0: begin
						bank_reg[bsel][CRF_SLOT_A0] <= wr_data[15:0];
						if (wr_size == CRF_SZ_LONG) begin
							bank_reg[bsel][CRF_SLOT_A1] <= wr_data[31:16];
						end
					end
					CRF_SEL_A1: bank_reg[bsel][CRF_SLOT_A1] <= wr_data[15:0];
					CRF_SEL_FB: bank_reg[bsel][CRF_SLOT_FB] <= wr_data[15:0];
					default: ;
				endcase
			end
		end
	end

	// unbanked words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sb_reg <= CRF_RST_WORD;
			usp_reg <= CRF_RST_WORD;
			isp_reg <= CRF_RST_WORD;
			vector_table_base_reg <= CRF_RST_WIDE;
		end else begin
			if (do_write) begin
				case (aw_idx_reg)
					CRF_IDX_SB: sb_reg <= 16'(merge_lanes({16'h0000, sb_reg}, w_data_reg, w_strb_reg));
					CRF_IDX_USP: usp_reg <= 16'(merge_lanes({16'h0000, usp_reg}, w_data_reg, w_strb_reg));
					CRF_IDX_ISP: isp_reg <= 16'(merge_lanes({16'h0000, isp_reg}, w_data_reg, w_strb_reg));
					CRF_IDX_VECTOR_TABLE_BASE: vector_table_base_reg <= 20'(merge_lanes({12'h000, vector_table_base_reg}, w_data_reg, w_strb_reg));
					default: ;
				endcase
			end
			if (wr_en) begin
				case (wr_sel)
					CRF_SEL_SB: sb_reg <= wr_data[15:0];
					CRF_SEL_USP: usp_reg <= wr_data[15:0];
					CRF_SEL_ISP: isp_reg <= wr_data[15:0];
					CRF_SEL_VECTOR_TABLE_BASE: vector_table_base_reg <= wr_data[19:0];
					CRF_SEL_SP: begin
						if (usel) begin
							usp_reg <= wr_data[15:0];
						end else begin
							isp_reg <= wr_data[15:0];
						end
					end
					default: ;
				endcase
			end
		end
	end

	// program counter: core write beats a step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_reg <= CRF_RST_WIDE;
		end else if (wr_en && wr_sel == CRF_SEL_PC) begin
			pc_reg <= wr_data[19:0];
		end else if (pc_step_en) begin
			pc_reg <= pc_reg + 20'(pc_step);
		end else if (do_write && aw_idx_reg == CRF_IDX_PC) begin
			pc_reg <= 20'(merge_lanes({12'h000, pc_reg}, w_data_reg, w_strb_reg));
		end
	end

	// flag word: interrupt events win over any write in the same cycle
	logic swint_low;
	logic [10:0] flg_wr;

	assign swint_low = sw_int_exec && (sw_int_num <= CRF_SWINT_STACK_MAX);

	always_comb begin
		flg_wr = flg_reg;
		if (do_write && aw_idx_reg == CRF_IDX_FLG) begin
			flg_wr = 11'(merge_lanes({21'h00_0000, flg_reg}, w_data_reg, w_strb_reg));
		end
		if (wr_en && wr_sel == CRF_SEL_FLG) begin
			flg_wr = wr_data[10:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flg_reg <= CRF_RST_FLAG;
		end else begin
			flg_reg <= flg_wr;
			if (hw_irq_ack || swint_low) begin
				flg_reg[CRF_FLG_U] <= 1'b0;
			end
			if (hw_irq_ack) begin
				flg_reg[CRF_FLG_I] <= 1'b0;
			end
		end
	end

	// core read ports, one cycle, values before this edge's writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_a_data <= 32'h0000_0000;
			rd_b_data <= 32'h0000_0000;
		end else begin
			rd_a_data <= read_op(rd_a_sel, rd_a_size, rd_a_hi, cur_bank[CRF_SLOT_D0], cur_bank[CRF_SLOT_D1],
				cur_bank[CRF_SLOT_D2], cur_bank[CRF_SLOT_D3], cur_bank[CRF_SLOT_A0], cur_bank[CRF_SLOT_A1],
				cur_bank[CRF_SLOT_FB], sp_cur);
			rd_b_data <= read_op(rd_b_sel, rd_b_size, rd_b_hi, cur_bank[CRF_SLOT_D0], cur_bank[CRF_SLOT_D1],
				cur_bank[CRF_SLOT_D2], cur_bank[CRF_SLOT_D3], cur_bank[CRF_SLOT_A0], cur_bank[CRF_SLOT_A1],
				cur_bank[CRF_SLOT_FB], sp_cur);
		end
	end

	// state outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			next_instr_pointer <= CRF_RST_WIDE;
			cpu_flag_word <= CRF_RST_FLAG;
		end else begin
			next_instr_pointer <= pc_reg;
			cpu_flag_word <= flg_reg;
		end
	end

	// axi4-lite read channel
	logic [4:0] ar_idx;
	logic [4:0] ar_rel;
	logic [31:0] ar_val;

	assign ar_idx = s_axi_araddr[6:2];

	always_comb begin
		ar_val = 32'h0000_0000;
		ar_rel = 5'h00;
		if (ar_idx < CRF_IDX_BANK0 + 5'(CRF_BANK_SLOTS)) begin
			ar_rel = ar_idx - CRF_IDX_BANK0;
			ar_val = {16'h0000, bank_reg[0][ar_rel[2:0]]};
		end else if (ar_idx >= CRF_IDX_BANK1 && ar_idx < CRF_IDX_BANK1 + 5'(CRF_BANK_SLOTS)) begin
			ar_rel = ar_idx - CRF_IDX_BANK1;
			ar_val = {16'h0000, bank_reg[1][ar_rel[2:0]]};
		end else begin
			case (ar_idx)
				CRF_IDX_VECTOR_TABLE_BASE: ar_val = {12'h000, vector_table_base_reg};
				CRF_IDX_PC: ar_val = {12'h000, pc_reg};
				CRF_IDX_USP: ar_val = {16'h0000, usp_reg};
				CRF_IDX_ISP: ar_val = {16'h0000, isp_reg};
				CRF_IDX_SB: ar_val = {16'h0000, sb_reg};
				CRF_IDX_FLG: ar_val = {21'h00_0000, flg_reg};
				CRF_IDX_SP: ar_val = {16'h0000, sp_cur};
				default: ar_val = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= CRF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= ar_val;
			s_axi_rresp <= idx_mapped(ar_idx) ? CRF_RESP_OKAY : CRF_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule : crf_core

`default_nettype wire

/* File: pkg/crf_pkg.sv */
// constants, selector and size encodings for the banked cpu register file
// assumes one clock domain; used by core/crf_core.sv and the bench
package crf_pkg;

	// architectural sizes
	localparam int CRF_ARCH_REGS = 13;
	localparam int CRF_BANKS = 2;
	localparam int CRF_BANK_SLOTS = 7;
	localparam int CRF_WORD_W = 16;
	localparam int CRF_BYTE_W = 8;
	localparam int CRF_LONG_W = 32;
	localparam int CRF_WIDE_W = 20;
	localparam int CRF_FLAG_W = 11;

	// slots inside one bank copy
	localparam logic [2:0] CRF_SLOT_D0 = 3'h0;
	localparam logic [2:0] CRF_SLOT_D1 = 3'h1;
	localparam logic [2:0] CRF_SLOT_D2 = 3'h2;
	localparam logic [2:0] CRF_SLOT_D3 = 3'h3;
	localparam logic [2:0] CRF_SLOT_A0 = 3'h4;
	localparam logic [2:0] CRF_SLOT_A1 = 3'h5;
	localparam logic [2:0] CRF_SLOT_FB = 3'h6;

	// flag word bit positions
	localparam int CRF_FLG_C = 0;
	localparam int CRF_FLG_D = 1;
	localparam int CRF_FLG_Z = 2;
	localparam int CRF_FLG_S = 3;
	localparam int CRF_FLG_B = 4;
	localparam int CRF_FLG_O = 5;
	localparam int CRF_FLG_I = 6;
	localparam int CRF_FLG_U = 7;
	localparam int CRF_FLG_IPL_LO = 8;
	localparam int CRF_FLG_IPL_W = 3;

	// reset values
	localparam logic [15:0] CRF_RST_WORD = 16'h0000;
	localparam logic [19:0] CRF_RST_WIDE = 20'h00000;
	localparam logic [10:0] CRF_RST_FLAG = 11'h000;

	// software interrupt numbers that switch to the interrupt stack
	localparam logic [5:0] CRF_SWINT_STACK_MAX = 6'h1f;

	// axi4-lite register map, word index = byte address / 4
	localparam logic [4:0] CRF_IDX_BANK0 = 5'h00;
	localparam logic [4:0] CRF_IDX_BANK1 = 5'h08;
	localparam logic [4:0] CRF_IDX_VECTOR_TABLE_BASE = 5'h10;
	localparam logic [4:0] CRF_IDX_PC = 5'h11;
	localparam logic [4:0] CRF_IDX_USP = 5'h12;
	localparam logic [4:0] CRF_IDX_ISP = 5'h13;
	localparam logic [4:0] CRF_IDX_SB = 5'h14;
	localparam logic [4:0] CRF_IDX_FLG = 5'h15;
	localparam logic [4:0] CRF_IDX_SP = 5'h16;
	localparam logic [1:0] CRF_RESP_OKAY = 2'h0;
	localparam logic [1:0] CRF_RESP_SLVERR = 2'h2;

	// operand selectors of the core ports
	typedef enum logic [3:0] {
		CRF_SEL_D0,
		CRF_SEL_D1,
		CRF_SEL_D2,
		CRF_SEL_D3,
		CRF_SEL_A0,
		CRF_SEL_A1,
		CRF_SEL_FB,
		CRF_SEL_SB,
		CRF_SEL_SP,
		CRF_SEL_USP,
		CRF_SEL_ISP,
		CRF_SEL_VECTOR_TABLE_BASE,
		CRF_SEL_PC,
		CRF_SEL_FLG
	} crf_sel_e;

	typedef enum logic [1:0] {
		CRF_SZ_BYTE,
		CRF_SZ_WORD,
		CRF_SZ_LONG
	} crf_size_e;

endpackage : crf_pkg

/* File: sim/crf_core_chk.sv */
// checker for the banked register file: flag events, pc stepping, axi4-lite handshakes
// assumes it is bound onto crf_core and that everything runs on aclk
`timescale 1ns/1ps
`default_nettype none
module crf_core_chk
	import crf_pkg::*;
#(
	parameter int AXI_ADDR_W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// core side
	input wire logic wr_en,
	input wire crf_sel_e wr_sel,
	input wire logic pc_step_en,
	input wire logic [2:0] pc_step,
	input wire logic hw_irq_ack,
	input wire logic sw_int_exec,
	input wire logic [5:0] sw_int_num,
	input wire logic [19:0] next_instr_pointer,
	input wire logic [10:0] cpu_flag_word,
	// axi4-lite
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// the pc copy lags the program counter by one edge
	property p_step;
		pc_step_en && !(wr_en && wr_sel == CRF_SEL_PC) && !s_axi_awvalid && !s_axi_bvalid
			|-> ##2 next_instr_pointer == 20'($past(next_instr_pointer) + $past(pc_step, 2));
	endproperty

	a_irq_clear: assert property (hw_irq_ack |-> ##2 !cpu_flag_word[CRF_FLG_U] && !cpu_flag_word[CRF_FLG_I])
		else $error("interrupt ack left stack or enable flag set");
	a_swint_clear: assert property (sw_int_exec && sw_int_num <= CRF_SWINT_STACK_MAX |-> ##2 !cpu_flag_word[CRF_FLG_U])
		else $error("software interrupt left stack select set");
	a_pc_step: assert property (p_step)
		else $error("program counter did not advance by the step");
	a_aw_to_b: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write accepted during response");
	a_ar_to_r: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not raised after address");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted during read data");

	c_irq: cover property (hw_irq_ack);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == CRF_RESP_SLVERR);
	c_step: cover property (pc_step_en);
endmodule : crf_core_chk

bind crf_core crf_core_chk #(.AXI_ADDR_W(AXI_ADDR_W)) chk_u (.aclk, .aresetn, .wr_en, .wr_sel, .pc_step_en,
	.pc_step, .hw_irq_ack, .sw_int_exec, .sw_int_num, .next_instr_pointer, .cpu_flag_word, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

/* File: sim/crf_dec_model.sv */
// decoder and alu stand-in driving the core ports of the register file
// assumes the bench calls its tasks from one process, all on aclk
`timescale 1ns/1ps
`default_nettype none
module crf_dec_model
	import crf_pkg::*;
(
	// clock
	input wire logic aclk,
	// read ports
	output var crf_sel_e rd_a_sel,
	output var crf_size_e rd_a_size,
	output var logic rd_a_hi,
	input wire logic [31:0] rd_a_data,
	output var crf_sel_e rd_b_sel,
	output var crf_size_e rd_b_size,
	output var logic rd_b_hi,
	input wire logic [31:0] rd_b_data,
	// write port
	output var logic wr_en,
	output var crf_sel_e wr_sel,
	output var crf_size_e wr_size,
	output var logic wr_hi,
	output var logic [31:0] wr_data,
	// events
	output var logic pc_step_en,
	output var logic [2:0] pc_step,
	output var logic hw_irq_ack,
	output var logic sw_int_exec,
	output var logic [5:0] sw_int_num
);
	initial begin
		{rd_a_hi, rd_b_hi, wr_en, wr_hi, pc_step_en, hw_irq_ack, sw_int_exec} = 7'h00;
		rd_a_sel = CRF_SEL_D0;
		rd_b_sel = CRF_SEL_D0;
		wr_sel = CRF_SEL_D0;
		rd_a_size = CRF_SZ_WORD;
		rd_b_size = CRF_SZ_WORD;
		wr_size = CRF_SZ_WORD;
		{wr_data, pc_step, sw_int_num} = 41'h0;
	end

	task automatic cw(input crf_sel_e s, input crf_size_e z, input logic h, input logic [31:0] d);
		@(posedge aclk);
		wr_en <= 1'b1;
		wr_sel <= s;
		wr_size <= z;
		{wr_hi, wr_data} <= {h, d};
		@(posedge aclk);
		wr_en <= 1'b0;
		// stale data is inverted so a write without enable cannot pass
		wr_data <= ~d;
	endtask : cw

	// port b reads the other byte half of the same operand
	task automatic cr(input crf_sel_e s, input crf_size_e z, input logic h, output logic [31:0] a,
		output logic [31:0] b);
		@(posedge aclk);
		rd_a_sel <= s;
		rd_b_sel <= s;
		rd_a_size <= z;
		rd_b_size <= z;
		rd_a_hi <= h;
		rd_b_hi <= !h;
		@(posedge aclk);
		#1;
		a = rd_a_data;
		b = rd_b_data;
	endtask : cr

	task automatic ev(input logic irq, input logic sw, input logic [5:0] n, input logic [2:0] st, input logic se);
		@(posedge aclk);
		{hw_irq_ack, sw_int_exec, sw_int_num, pc_step, pc_step_en} <= {irq, sw, n, st, se};
		@(posedge aclk);
		{hw_irq_ack, sw_int_exec, pc_step_en} <= 3'h0;
	endtask : ev
endmodule : crf_dec_model
`default_nettype wire

/* File: sim/test_cpu_register_file_banked.sv */
// self-checking bench for the banked register file, axi4-lite and core ports
// assumes crf_core and crf_dec_model; shadow array indexed by register word index
`timescale 1ns/1ps
`default_nettype none
module test_cpu_register_file_banked
	import crf_pkg::*;
();
	logic aclk = 1'b0;
	logic aresetn;
	crf_sel_e rd_a_sel, rd_b_sel, wr_sel;
	crf_size_e rd_a_size, rd_b_size, wr_size;
	logic rd_a_hi, rd_b_hi, wr_en, wr_hi, pc_step_en, hw_irq_ack, sw_int_exec;
	logic [31:0] rd_a_data, rd_b_data, wr_data, s_axi_wdata, s_axi_rdata;
	logic [2:0] pc_step;
	logic [5:0] sw_int_num;
	logic [19:0] next_instr_pointer;
	logic [10:0] cpu_flag_word;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int bad_count = 0;
	int checks_done = 0;
	logic [31:0] seed = 32'h3dfa20ce;
	logic [31:0] sh [0:23];
	localparam logic [5:0] INT_NUMS [5] = '{6'h00, 6'h00, 6'h1f, 6'h20, 6'h3f};

	always #4 aclk = ~aclk;

	crf_dec_model dec_u (.aclk, .rd_a_sel, .rd_a_size, .rd_a_hi, .rd_a_data, .rd_b_sel, .rd_b_size, .rd_b_hi,
		.rd_b_data, .wr_en, .wr_sel, .wr_size, .wr_hi, .wr_data, .pc_step_en, .pc_step, .hw_irq_ack,
		.sw_int_exec, .sw_int_num);
	crf_core #(.AXI_ADDR_W(8)) dut_u (.aclk, .aresetn, .rd_a_sel, .rd_a_size, .rd_a_hi, .rd_a_data, .rd_b_sel,
		.rd_b_size, .rd_b_hi, .rd_b_data, .wr_en, .wr_sel, .wr_size, .wr_hi, .wr_data, .pc_step_en, .pc_step,
		.hw_irq_ack, .sw_int_exec, .sw_int_num, .next_instr_pointer, .cpu_flag_word, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	function automatic logic [31:0] msk(input int i);
		if (i == 7 || i == 15 || i > 21) return 32'h0;
		if (i == 16 || i == 17) return 32'hfffff;
		return (i == 21) ? 32'h7ff : 32'hffff;
	endfunction : msk

	function automatic int ix(input crf_sel_e s);
		case (s)
			CRF_SEL_SB: return 20;
			CRF_SEL_SP: return sh[21][7] ? 18 : 19;
			CRF_SEL_USP: return 18;
			CRF_SEL_ISP: return 19;
			CRF_SEL_VECTOR_TABLE_BASE: return 16;
			CRF_SEL_PC: return 17;
			CRF_SEL_FLG: return 21;
			default: return (sh[21][4] ? 8 : 0) + int'(s);
		endcase
	endfunction : ix

	function automatic logic pair(input crf_sel_e s, input crf_size_e z);
		return z == CRF_SZ_LONG && (s <= CRF_SEL_D1 || s == CRF_SEL_A0);
	endfunction : pair

	function automatic logic [31:0] ce(input crf_sel_e s, input crf_size_e z, input logic h);
		int i;
		i = ix(s);
		if (z == CRF_SZ_BYTE && s <= CRF_SEL_D1) return h ? {24'h0, sh[i][15:8]} : {24'h0, sh[i][7:0]};
		if (pair(s, z)) return {sh[i + (s == CRF_SEL_A0 ? 1 : 2)][15:0], sh[i][15:0]};
		return sh[i];
	endfunction : ce

	function automatic void upd(input crf_sel_e s, input crf_size_e z, input logic h, input logic [31:0] d);
		int i;
		i = ix(s);
		if (z == CRF_SZ_BYTE && s <= CRF_SEL_D1) begin
			if (h) sh[i][15:8] = d[7:0];
			else sh[i][7:0] = d[7:0];
		end else if (pair(s, z)) begin
			sh[i] = {16'h0, d[15:0]};
			sh[i + (s == CRF_SEL_A0 ? 1 : 2)] = {16'h0, d[31:16]};
		end else sh[i] = d & msk(i);
	endfunction : upd

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic print_verdict();
		if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic axw(input int i, input logic [31:0] d, input logic [3:0] st);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {8'(i * 4), d, st};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		// only the watchdog ends a wait for the response
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		chk("bresp", {30'h0, s_axi_bresp}, (i == 7 || i == 15 || i == 23) ? 32'h2 : 32'h0);
		s_axi_bready <= 1'b0;
	endtask : axw

	task automatic axr(input int i, input logic [31:0] exp);
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {8'(i * 4), 2'h3};
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		chk("rdata", s_axi_rdata, exp);
		chk("rresp", {30'h0, s_axi_rresp}, (i == 7 || i == 15 || i == 23) ? 32'h2 : 32'h0);
		s_axi_rready <= 1'b0;
	endtask : axr

	task automatic sweep();
		for (int i = 0; i < 24; i++) axr(i, (i == 22) ? sh[sh[21][7] ? 18 : 19] : sh[i]);
	endtask : sweep

	initial begin
		repeat (30000) @(posedge aclk);
		bad_count++;
		print_verdict();
	end

	initial begin
		logic [31:0] v, a, b;
		logic [3:0] st;
		crf_sel_e s;
		crf_size_e z;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		for (int i = 0; i < 24; i++) sh[i] = 32'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		sweep();
		// lane-strobed writes everywhere, unmapped and read-only places included
		for (int i = 0; i < 24; i++) begin
			v = xs();
			st = 4'(xs());
			axw(i, v, st);
			a = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
			sh[i] = ((sh[i] & ~a) | (v & a)) & msk(i);
		end
		sweep();
		for (int k = 0; k < 120; k++) begin
			s = crf_sel_e'(4'(xs() % 14));
			z = crf_size_e'(2'(xs() % 3));
			v = xs();
			dec_u.cw(s, z, v[0], v);
			upd(s, z, v[0], v);
			s = crf_sel_e'(4'(xs() % 14));
			z = crf_size_e'(2'(xs() % 3));
			dec_u.cr(s, z, v[1], a, b);
			chk("read a", a, ce(s, z, v[1]));
			chk("read b", b, ce(s, z, !v[1]));
		end
		sweep();
		for (int k = 0; k < 5; k++) begin
			axw(21, 32'h0d0, 4'hf);
			sh[21] = 32'h0d0;
			dec_u.ev(k == 0, k != 0, INT_NUMS[k], 3'h0, 1'b0);
			if (k == 0 || INT_NUMS[k] <= CRF_SWINT_STACK_MAX) sh[21][7] = 1'b0;
			if (k == 0) sh[21][6] = 1'b0;
			axr(21, sh[21]);
			axr(22, sh[sh[21][7] ? 18 : 19]);
			chk("flag copy", {21'h0, cpu_flag_word}, sh[21]);
		end
		for (int k = 0; k < 4; k++) begin
			v = (k == 0) ? 32'hffffe : xs();
			axw(17, v, 4'hf);
			st = (k == 0) ? 4'h7 : 4'(xs() % 8);
			dec_u.ev(1'b0, 1'b0, 6'h0, st[2:0], 1'b1);
			sh[17] = (v + 32'(st)) & 32'hfffff;
			axr(17, sh[17]);
			chk("pc copy", {12'h0, next_instr_pointer}, sh[17]);
		end
		print_verdict();
	end
endmodule : test_cpu_register_file_banked
`default_nettype wire
